// ---- gdps_pkg.sv ----
// package of constants for the duty-cycle power sequencer
// Notes on behaviour
// - sleep keeps supply, stops the navigation engine and powers RF down.
// - an rtc wake-up tick ends each sleep and powers engine and RF back on.
// - no acquisition within 150 s gives 30 s sleep, wake, reset, retry.
// - after reset stay full power until fix, ephemeris and rtc calibration.
// - push-to-fix alternates 29.5 min sleep with 30 s tracking.
// - only one low-power mode active; selecting one cancels the other.
// - low reset in push-to-fix forces reset, hot start up to 8 s, fix, sleep.
// - sentence carries three comma fields, asterisk, checksum, cr lf.
// - mode field 0 selects trickle, 1 selects push-to-fix.
// - duty cycle in tenths of percent, at most 1000, tracking fraction.
// - on time in ms from 200 to 900; larger values refused.
// - checksum is checked before the sentence takes effect.
// - trickle off time is on time times (1 - duty) over duty; period is sum.
// - push-to-fix off period 10 to 7200 s, default 1800 s.
// - push-to-fix wake calibrates rtc, gets ephemeris only when needed.
// - after reset run continuous full power until low-power is commanded.
// - trickle starts once navigation valid; default 800 ms off, 200 ms on.
// - low level on the reset input resets the whole unit.
package gdps_pkg;
   // ========================================
   // clock and time base
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   // ========================================
   // timing figures
   localparam int unsigned ACQ_TIMEOUT_S = 150;
   localparam int unsigned RETRY_SLEEP_S = 30;
   localparam int unsigned PTF_TRACK_S = 30;
   localparam int unsigned PTF_SLEEP_DS = 17700;
   localparam int unsigned PTF_OFF_DEF_S = 1800;
   localparam int unsigned PTF_OFF_MIN_S = 10;
   localparam int unsigned PTF_OFF_MAX_S = 7200;
   localparam int unsigned HOT_START_S = 8;
   localparam int unsigned RESET_HOLD_MS = 1;
   localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * MS_CYCLES;
   // ========================================
   // sentence fields and defaults
   localparam logic [9:0] ON_MIN_MS = 10'h0C8;
   localparam logic [9:0] ON_MAX_MS = 10'h384;
   localparam logic [9:0] DUTY_MAX = 10'h3E8;
   localparam logic [9:0] ON_DEF_MS = 10'h0C8;
   localparam logic [9:0] DUTY_DEF = 10'h0C8;
   localparam logic [7:0] CH_DOLLAR = 8'h24;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_STAR = 8'h2A;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] HDR_LEN = 8'h07;
   localparam logic [55:0] HDR_TEXT = 56'h5053_5246_3130_37;
   typedef enum logic [1:0] {GDPS_MODE_CONT, GDPS_MODE_TRICKLE, GDPS_MODE_PTF} gdps_mode_e;
endpackage : gdps_pkg

// ---- gdps_sequencer.sv ----
// duty-cycle power sequencer with configuration sentence decoder
`timescale 1ns/1ns
module gdps_sequencer
#(
   parameter int unsigned MS_CYC = gdps_pkg::MS_CYCLES,
   parameter int unsigned RESET_CYC = gdps_pkg::RESET_HOLD_CYC
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // external pin reset, active low
   input wire logic reset_n_i,
   // serial characters from the uart
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_char_i,
   // navigation status and push-to-fix off period from firmware
   input wire logic nav_fix_i,
   input wire logic eph_complete_i,
   input wire logic eph_needed_i,
   input wire logic rtc_cal_done_i,
   input wire logic ptf_off_valid_i,
   input wire logic [12:0] ptf_off_s_i,
   // power controls and configuration outputs
   output logic engine_on_o,
   output logic rf_on_o,
   output logic rtc_cal_req_o,
   output logic eph_collect_o,
   output logic unit_reset_o,
   output logic [1:0] mode_o,
   output logic [9:0] duty_o,
   output logic [9:0] on_ms_o,
   output logic cfg_err_o
);
   // ========================================
   // millisecond tick
   logic [31:0] div_q;
   logic ms_tick;
   assign ms_tick = (div_q == MS_CYC - 1);
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i) div_q <= '0;
      else div_q <= ms_tick ? '0 : div_q + 32'd1;
   end
   // ========================================
   // pin reset synchroniser, three stages
   logic [2:0] rsn_q;
   logic pin_low_q;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rsn_q <= 3'b111;
         pin_low_q <= 1'b0;
      end
      else
      begin
         rsn_q <= {rsn_q[1:0], reset_n_i};
         if (rsn_q[1] == rsn_q[2]) pin_low_q <= ~rsn_q[2];
      end
   end
   // ========================================
   // sentence parser
   function automatic logic [3:0] hex_val(input logic [7:0] c);
      hex_val = (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
   endfunction : hex_val
   function automatic logic is_hex(input logic [7:0] c);
      is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
   endfunction : is_hex
   typedef enum logic [2:0] {P_IDLE, P_HDR, P_FLD, P_CK1, P_CK2, P_CR, P_LF} gdps_ps_e;
   gdps_ps_e ps_q;
   logic [7:0] xor_q, hcnt_q, ckv_q;
   logic [1:0] fidx_q;
   logic [12:0] acc_q;
   logic [12:0] f0_q, f1_q;
   logic bad_q;
   logic cfg_load;
   logic [55:0] hdr_sh;
   logic [7:0] hdr_exp;
   logic is_digit;
   logic [12:0] acc_next;
   logic fields_ok;
   assign is_digit = (rx_char_i >= 8'h30) && (rx_char_i <= 8'h39);
   assign acc_next = 13'(acc_q * 13'd10 + 13'(rx_char_i - 8'h30));
   assign hdr_sh = gdps_pkg::HDR_TEXT >> (8 * (gdps_pkg::HDR_LEN - 8'd1 - hcnt_q));
   assign hdr_exp = hdr_sh[7:0];
   assign fields_ok = (f0_q <= 13'd1) && (f1_q <= 13'(gdps_pkg::DUTY_MAX)) && (f1_q != 0)
      && (acc_q >= 13'(gdps_pkg::ON_MIN_MS)) && (acc_q <= 13'(gdps_pkg::ON_MAX_MS));
   // accept only on matching checksum and good fields
   assign cfg_load = rx_valid_i && ps_q == P_LF && rx_char_i == gdps_pkg::CH_LF && !bad_q
      && fidx_q == 2'd2 && fields_ok;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ps_q <= P_IDLE;
         xor_q <= '0;
         hcnt_q <= '0;
         ckv_q <= '0;
         fidx_q <= '0;
         acc_q <= '0;
         f0_q <= '0;
         f1_q <= '0;
         bad_q <= 1'b0;
      end
      else if (rx_valid_i)
      begin
         // a dollar always restarts the sentence
         if (rx_char_i == gdps_pkg::CH_DOLLAR)
         begin
            ps_q <= P_HDR;
            xor_q <= '0;
            hcnt_q <= '0;
            fidx_q <= '0;
            acc_q <= '0;
            bad_q <= 1'b0;
         end
         else
         begin
            unique case (ps_q)
               P_IDLE: ps_q <= P_IDLE;
               P_HDR:
               begin
                  xor_q <= xor_q ^ rx_char_i;
                  if (hcnt_q == gdps_pkg::HDR_LEN)
                     ps_q <= (rx_char_i == gdps_pkg::CH_COMMA) ? P_FLD : P_IDLE;
                  else if (rx_char_i == hdr_exp) hcnt_q <= hcnt_q + 8'd1;
                  else ps_q <= P_IDLE;
               end
               P_FLD:
               begin
                  if (rx_char_i == gdps_pkg::CH_STAR) ps_q <= P_CK1;
                  else
                  begin
                     xor_q <= xor_q ^ rx_char_i;
                     if (rx_char_i == gdps_pkg::CH_COMMA)
                     begin
                        if (fidx_q == 2'd0) f0_q <= acc_q;
                        else if (fidx_q == 2'd1) f1_q <= acc_q;
                        if (fidx_q == 2'd2) bad_q <= 1'b1;
                        else fidx_q <= fidx_q + 2'd1;
                        acc_q <= '0;
                     end
                     else if (is_digit)
                     begin
                        // another digit on 819 or more would wrap the 13-bit accumulator
                        if (acc_q > 13'h0332) bad_q <= 1'b1;
                        acc_q <= acc_next;
                     end
                     else if (rx_char_i != 8'h20) bad_q <= 1'b1;
                  end
               end
               P_CK1:
               begin
                  if (!is_hex(rx_char_i)) bad_q <= 1'b1;
                  ckv_q <= {hex_val(rx_char_i), 4'h0};
                  ps_q <= P_CK2;
               end
               P_CK2:
               begin
                  if (!is_hex(rx_char_i) || {ckv_q[7:4], hex_val(rx_char_i)} != xor_q)
                     bad_q <= 1'b1;
                  ps_q <= P_CR;
               end
               P_CR: ps_q <= (rx_char_i == gdps_pkg::CH_CR) ? P_LF : P_IDLE;
               P_LF: ps_q <= P_IDLE;
            endcase
         end
      end
   end
   // ========================================
   // configuration registers
   logic [1:0] mode_q;
   logic [9:0] duty_q, on_q;
   logic err_q;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_q <= gdps_pkg::GDPS_MODE_CONT;
         duty_q <= gdps_pkg::DUTY_DEF;
         on_q <= gdps_pkg::ON_DEF_MS;
         err_q <= 1'b0;
      end
      else if (cfg_load)
      begin
         // one mode register, so a new mode replaces the old
         mode_q <= (f0_q == 13'd0) ? gdps_pkg::GDPS_MODE_TRICKLE : gdps_pkg::GDPS_MODE_PTF;
         duty_q <= f1_q[9:0];
         on_q <= acc_q[9:0];
         err_q <= 1'b0;
      end
      else if (rx_valid_i && ps_q == P_LF) err_q <= 1'b1;
   end
   // off time in ms: on * (1000 - duty) / duty, kept wide as it reaches 899100
   logic [19:0] off_num;
   logic [19:0] off_ms;
   assign off_num = 20'(on_q * 20'(gdps_pkg::DUTY_MAX - duty_q));
   assign off_ms = off_num / 20'(duty_q);
   // off period with range check and default
   logic [12:0] ptf_off;
   assign ptf_off = (ptf_off_valid_i && ptf_off_s_i >= 13'(gdps_pkg::PTF_OFF_MIN_S)
      && ptf_off_s_i <= 13'(gdps_pkg::PTF_OFF_MAX_S)) ? ptf_off_s_i : 13'(gdps_pkg::PTF_OFF_DEF_S);
   // ========================================
   // power sequencer
   typedef enum logic [2:0] {S_INIT, S_TRACK, S_SLEEP, S_RETRY, S_RESET} gdps_ss_e;
   gdps_ss_e ss_q;
   logic [23:0] tmr_q;
   logic wake;
   logic ready;
   logic [23:0] sleep_ms;
   assign ready = nav_fix_i && eph_complete_i && rtc_cal_done_i;
   // 29.5 min sleep when the off period is left at its default
   assign sleep_ms = (mode_q == gdps_pkg::GDPS_MODE_PTF) ?
      ((ptf_off == 13'(gdps_pkg::PTF_OFF_DEF_S)) ? 24'(gdps_pkg::PTF_SLEEP_DS * 100)
      : 24'(ptf_off * 1000)) : 24'(off_ms);
   // rtc wake-up when the sleep count runs out
   assign wake = ms_tick && tmr_q == 24'd0;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ss_q <= S_INIT;
         tmr_q <= '0;
      end
      // pin reset restarts the unit with a hot start
      else if (pin_low_q && ss_q != S_RESET)
      begin
         ss_q <= S_RESET;
         tmr_q <= 24'(RESET_CYC);
      end
      else
      begin
         unique case (ss_q)
            // full power until ready and a low-power mode is set
            S_INIT:
            begin
               if (ms_tick) tmr_q <= tmr_q + 24'd1;
               if (ready && mode_q != gdps_pkg::GDPS_MODE_CONT)
               begin
                  ss_q <= S_SLEEP;
                  tmr_q <= sleep_ms;
               end
               // acquisition timeout leads to a retry sleep
               else if (!nav_fix_i && tmr_q >= 24'(gdps_pkg::ACQ_TIMEOUT_S * 1000))
               begin
                  ss_q <= S_RETRY;
                  tmr_q <= 24'(gdps_pkg::RETRY_SLEEP_S * 1000);
               end
            end
            S_RETRY:
            begin
               if (wake) ss_q <= S_RESET;
               else if (ms_tick) tmr_q <= tmr_q - 24'd1;
               if (wake) tmr_q <= 24'(RESET_CYC);
            end
            S_RESET:
            begin
               if (!pin_low_q && tmr_q == 24'd0)
               begin
                  ss_q <= S_INIT;
                  tmr_q <= '0;
               end
               else if (tmr_q != 24'd0) tmr_q <= tmr_q - 24'd1;
            end
            S_SLEEP:
            begin
               if (mode_q == gdps_pkg::GDPS_MODE_CONT) ss_q <= S_INIT;
               else if (wake)
               begin
                  ss_q <= S_TRACK;
                  tmr_q <= (mode_q == gdps_pkg::GDPS_MODE_PTF) ?
                     24'(gdps_pkg::PTF_TRACK_S * 1000) : 24'(on_q);
               end
               else if (ms_tick) tmr_q <= tmr_q - 24'd1;
            end
            S_TRACK:
            begin
               // push-to-fix with no ephemeris needed: sleep as soon as calibrated
               if (wake || (mode_q == gdps_pkg::GDPS_MODE_PTF && !eph_needed_i
                  && rtc_cal_done_i))
               begin
                  ss_q <= S_SLEEP;
                  tmr_q <= sleep_ms;
               end
               else if (ms_tick) tmr_q <= tmr_q - 24'd1;
            end
            default: ss_q <= S_INIT;
         endcase
      end
   end
   // ========================================
   // registered outputs
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         engine_on_o <= 1'b0;
         rf_on_o <= 1'b0;
         rtc_cal_req_o <= 1'b0;
         eph_collect_o <= 1'b0;
         unit_reset_o <= 1'b1;
         mode_o <= gdps_pkg::GDPS_MODE_CONT;
         duty_o <= gdps_pkg::DUTY_DEF;
         on_ms_o <= gdps_pkg::ON_DEF_MS;
         cfg_err_o <= 1'b0;
      end
      else
      begin
         // sleep states shut engine and RF, supply stays on
         engine_on_o <= (ss_q == S_INIT) || (ss_q == S_TRACK);
         rf_on_o <= (ss_q == S_INIT) || (ss_q == S_TRACK);
         rtc_cal_req_o <= ss_q == S_TRACK && mode_q == gdps_pkg::GDPS_MODE_PTF;
         eph_collect_o <= ss_q == S_TRACK && mode_q == gdps_pkg::GDPS_MODE_PTF && eph_needed_i;
         unit_reset_o <= ss_q == S_RESET;
         mode_o <= mode_q;
         duty_o <= duty_q;
         on_ms_o <= on_q;
         cfg_err_o <= err_q;
      end
   end
endmodule : gdps_sequencer

// ---- gdps_seq_chk.sv ----
// port assertions for the duty-cycle power sequencer
`timescale 1ns/1ns
module gdps_seq_chk
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reset_n_i,
   // power and configuration outputs
   input wire logic engine_on_o,
   input wire logic rf_on_o,
   input wire logic eph_collect_o,
   input wire logic unit_reset_o,
   input wire logic [1:0] mode_o,
   input wire logic [9:0] duty_o,
   input wire logic [9:0] on_ms_o,
   input wire logic cfg_err_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ========================================
   // assertions
   a_rf_with_engine: assert property ($fell(engine_on_o) |-> !rf_on_o)
      else $error("rf stays powered after engine shut off");
   a_wake_both_on: assert property ($rose(engine_on_o) |-> rf_on_o)
      else $error("engine woke without rf");
   a_sleep_needs_mode: assert property ($fell(engine_on_o) && !unit_reset_o
      |-> mode_o != 2'h0)
      else $error("sleep entered in continuous mode");
   a_single_mode: assert property (mode_o != 2'h3)
      else $error("illegal mode code");
   a_duty_range: assert property (duty_o != 10'h000 && duty_o <= gdps_pkg::DUTY_MAX)
      else $error("duty cycle out of range");
   a_on_range: assert property (on_ms_o >= gdps_pkg::ON_MIN_MS
      && on_ms_o <= gdps_pkg::ON_MAX_MS)
      else $error("on time out of range");
   a_reject_keeps: assert property ($rose(cfg_err_o) |-> $stable(mode_o)
      && $stable(duty_o) && $stable(on_ms_o))
      else $error("rejected sentence changed configuration");
   a_pin_resets: assert property (!reset_n_i [*8] |-> unit_reset_o)
      else $error("low reset pin did not reset the unit");
   a_eph_in_ptf: assert property (eph_collect_o |-> mode_o == 2'h2 && engine_on_o)
      else $error("ephemeris collection outside push-to-fix tracking");
   // ========================================
   // coverage
   c_trickle_sleep: cover property ($fell(engine_on_o) && mode_o == 2'h1);
   c_ptf_sleep: cover property ($fell(engine_on_o) && mode_o == 2'h2);
   c_reject: cover property ($rose(cfg_err_o));
   c_pin_reset: cover property ($rose(unit_reset_o));
endmodule : gdps_seq_chk

// ---- gdps_host.sv ----
// host model that sends low-power configuration sentences
`timescale 1ns/1ns
module gdps_host
(
   // clock
   input wire logic clk_i,
   // serial characters to the sequencer
   output logic rx_valid_o,
   output logic [7:0] rx_char_o
);
   logic [7:0] fr[$];
   initial
   begin
      rx_valid_o = 1'b0;
      rx_char_o = 8'h00;
   end
   function automatic void num(input int v);
      for (int p = 1000; p >= 1; p = p / 10)
      begin
         if (v >= p || p == 1)
         begin
            fr.push_back(8'h30 + 8'((v / p) % 10));
         end
      end
   endfunction : num
   function automatic logic [7:0] hex(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction : hex
   // ========================================
   // sentence sender; bad flips one checksum bit
   task automatic send(input int m, input int d, input int o, input logic bad);
      logic [7:0] sum;
      sum = 8'h00;
      fr = {};
      for (int i = 6; i >= 0; i--)
      begin
         fr.push_back(gdps_pkg::HDR_TEXT[i*8 +: 8]);
      end
      fr.push_back(gdps_pkg::CH_COMMA);
      num(m);
      fr.push_back(gdps_pkg::CH_COMMA);
      num(d);
      fr.push_back(gdps_pkg::CH_COMMA);
      num(o);
      foreach (fr[i])
      begin
         sum = sum ^ fr[i];
      end
      sum = sum ^ {7'h00, bad};
      fr.push_front(gdps_pkg::CH_DOLLAR);
      fr.push_back(gdps_pkg::CH_STAR);
      fr.push_back(hex(sum[7:4]));
      fr.push_back(hex(sum[3:0]));
      fr.push_back(gdps_pkg::CH_CR);
      fr.push_back(gdps_pkg::CH_LF);
      // characters back to back, the fastest rate the link allows
      foreach (fr[i])
      begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_char_o <= fr[i];
      end
      // idle data shows the inverse so a stale character is never reused
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_char_o <= ~fr[fr.size() - 1];
   endtask : send
endmodule : gdps_host

// ---- gdps_sequencer_test.sv ----
// self-checking testbench for the duty-cycle power sequencer
`timescale 1ns/1ns
module gdps_sequencer_test;
   // short millisecond so sleeps fit the run
   localparam int unsigned MSC = 2;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reset_n_i = 1'b1;
   logic nav_fix_i = 1'b0;
   logic eph_complete_i = 1'b0;
   logic eph_needed_i = 1'b1;
   logic rtc_cal_done_i = 1'b0;
   logic ptf_off_valid_i = 1'b1;
   logic [12:0] ptf_off_s_i = 13'h000A;
   logic rx_valid_i;
   logic [7:0] rx_char_i;
   logic engine_on_o, rf_on_o, rtc_cal_req_o, eph_collect_o, unit_reset_o, cfg_err_o;
   logic [1:0] mode_o;
   logic [9:0] duty_o, on_ms_o;
   int err_count = 0;
   int checked = 0;
   int n;
   always #2 clk_i = ~clk_i;
   gdps_sequencer #(.MS_CYC(MSC), .RESET_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
      .nav_fix_i(nav_fix_i), .eph_complete_i(eph_complete_i), .eph_needed_i(eph_needed_i),
      .rtc_cal_done_i(rtc_cal_done_i), .ptf_off_valid_i(ptf_off_valid_i),
      .ptf_off_s_i(ptf_off_s_i), .engine_on_o(engine_on_o), .rf_on_o(rf_on_o),
      .rtc_cal_req_o(rtc_cal_req_o), .eph_collect_o(eph_collect_o),
      .unit_reset_o(unit_reset_o), .mode_o(mode_o), .duty_o(duty_o), .on_ms_o(on_ms_o),
      .cfg_err_o(cfg_err_o));
   gdps_host u_host (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i));
   // ========================================
   // helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [15:0] near(input int v, input int e);
      return 16'(v >= e - 6 && v <= e + 6);
   endfunction : near
   task automatic wait_eng(input logic lvl, input int max);
      n = 0;
      while (engine_on_o !== lvl && n < max)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      // a wait that runs out counts as a mismatch
      if (n == max) check("engine_wait", 16'(engine_on_o), 16'(lvl));
   endtask : wait_eng
   task automatic cfg(input int m, d, o, input logic bad, input logic [1:0] em,
      input logic [9:0] ed, eo, input logic ee);
      u_host.send(m, d, o, bad);
      repeat (3) @(posedge clk_i);
      #1;
      check("mode", 16'(mode_o), 16'(em));
      check("duty", 16'(duty_o), 16'(ed));
      check("on_ms", 16'(on_ms_o), 16'(eo));
      check("cfg_err", 16'(cfg_err_o), 16'(ee));
   endtask : cfg
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // ========================================
   // scenarios
   task automatic t_reset();
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check("mode", 16'(mode_o), 16'h0000);
      check("power", 16'({engine_on_o, rf_on_o, unit_reset_o}), 16'h0006);
   endtask : t_reset
   task automatic t_trickle();
      cfg(0, 500, 200, 1'b0, 2'h1, 10'h1F4, 10'h0C8, 1'b0);
      repeat (50) @(posedge clk_i);
      #1;
      check("no_early_sleep", 16'(engine_on_o), 16'h0001);
      @(posedge clk_i);
      nav_fix_i <= 1'b1;
      eph_complete_i <= 1'b1;
      rtc_cal_done_i <= 1'b1;
      wait_eng(1'b0, 20);
      check("sleep_entry", 16'(n < 20 && !rf_on_o), 16'h0001);
      wait_eng(1'b1, 2000);
      check("trickle_off", near(n, 200 * (1000 - 500) / 500 * MSC), 16'h0001);
      wait_eng(1'b0, 2000);
      check("trickle_on", near(n, 200 * MSC), 16'h0001);
   endtask : t_trickle
   task automatic t_reject();
      int tm[6] = '{0, 0, 0, 2, 0, 0};
      int td[6] = '{300, 1001, 0, 300, 300, 300};
      int to[6] = '{300, 300, 300, 300, 950, 150};
      for (int i = 0; i < 6; i++)
      begin
         cfg(tm[i], td[i], to[i], i == 0, 2'h1, 10'h1F4, 10'h0C8, 1'b1);
      end
   endtask : t_reject
   task automatic t_ptf();
      @(posedge clk_i);
      eph_needed_i <= 1'b0;
      cfg(1, 100, 300, 1'b0, 2'h2, 10'h064, 10'h12C, 1'b0);
      wait_eng(1'b1, 70000);
      wait_eng(1'b0, 70000);
      wait_eng(1'b1, 30000);
      check("ptf_off", near(n, 10 * 1000 * MSC), 16'h0001);
      // with nothing to collect the tracking phase lasts a single cycle
      check("cal_only", 16'({rtc_cal_req_o, eph_collect_o}), 16'h0002);
      wait_eng(1'b0, 40);
      check("prompt_off", 16'(n < 40), 16'h0001);
      @(posedge clk_i);
      eph_needed_i <= 1'b1;
      wait_eng(1'b1, 30000);
      repeat (2) @(posedge clk_i);
      #1;
      check("eph_collect", 16'(eph_collect_o), 16'h0001);
   endtask : t_ptf
   task automatic t_pin();
      @(posedge clk_i);
      // firmware loses its fix while the unit is held in reset
      reset_n_i <= 1'b0;
      nav_fix_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      check("pin_reset", 16'(unit_reset_o), 16'h0001);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      eph_needed_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      #1;
      check("hot_start", 16'({unit_reset_o, engine_on_o, mode_o}), 16'h0006);
      @(posedge clk_i);
      nav_fix_i <= 1'b1;
      wait_eng(1'b0, 60);
      check("resleep", 16'(n < 60), 16'h0001);
   endtask : t_pin
   initial
   begin
      t_reset();
      t_trickle();
      t_reject();
      t_ptf();
      t_pin();
      test_done();
   end
   // whole sequence needs about 42000 cycles, the limit allows 80000
   initial
   begin
      #320000;
      err_count++;
      test_done();
   end
endmodule : gdps_sequencer_test
bind gdps_sequencer gdps_seq_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
   .engine_on_o(engine_on_o), .rf_on_o(rf_on_o), .eph_collect_o(eph_collect_o),
   .unit_reset_o(unit_reset_o), .mode_o(mode_o), .duty_o(duty_o), .on_ms_o(on_ms_o),
   .cfg_err_o(cfg_err_o));
